//--- pkg/pcoc_ctl_if.sv
/*
 * Carries one channel's stored control fields from the register bank
 * to the loop mode logic and the top. Assumes one shared clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface pcoc_ctl_if;
    import pcoc_pkg::*;

    logic [3:0] out_ctl;
    logic [1:0] man_ref;
    pcoc_swmode_e sw_mode;
    logic user_hold;
    logic user_free;
    logic [2:0] rst_act;

    modport bank (
        output out_ctl,
        output man_ref,
        output sw_mode,
        output user_hold,
        output user_free,
        output rst_act
    );

    modport user (
        input out_ctl,
        input man_ref,
        input sw_mode,
        input user_hold,
        input user_free,
        input rst_act
    );
endinterface

`default_nettype wire

//--- pkg/pcoc_params.svh
/*
 * Address map, field positions and reset values of the PLL channel
 * control bank. Assumes a byte-wide register port with 16-bit addresses.
 */
`ifndef PCOC_PARAMS_SVH
`define PCOC_PARAMS_SVH

// ----------------------------------------------------------------------
// addresses
// ----------------------------------------------------------------------
`define PCOC_ADDR_OUTPUT 16'h0A21
`define PCOC_ADDR_MODE 16'h0A22
`define PCOC_ADDR_RESET 16'h0A23
`define PCOC_ADDR_STATUS 16'h0A2F
`define PCOC_CH_STRIDE 16'h0020

// ----------------------------------------------------------------------
// output control fields
// ----------------------------------------------------------------------
`define PCOC_OUT_B_DIS 3
`define PCOC_OUT_A_DIS 2
`define PCOC_OUT_B_PD 1
`define PCOC_OUT_A_PD 0
`define PCOC_OUT_RST_VAL 4'h0

// ----------------------------------------------------------------------
// user mode fields
// ----------------------------------------------------------------------
`define PCOC_REF_HI 6
`define PCOC_REF_LO 5
`define PCOC_SW_HI 4
`define PCOC_SW_LO 2
`define PCOC_HOLD_BIT 1
`define PCOC_FREE_BIT 0
`define PCOC_REF_RST_VAL 2'h0

// ----------------------------------------------------------------------
// self-clearing reset fields
// ----------------------------------------------------------------------
`define PCOC_RST_FILT 2
`define PCOC_RST_HIST 1
`define PCOC_RST_SYNC 0
`define PCOC_RST_RST_VAL 3'h0

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define PCOC_ST_FREE 0
`define PCOC_ST_HOLD 1
`define PCOC_ST_HIST 2

`endif

//--- pkg/pcoc_pkg.sv
/*
 * Types shared by the PLL channel control bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pcoc_pkg;

    typedef logic [7:0] pcoc_byte_t;

    typedef enum logic [2:0] {
        PCOC_SW_AUTO_REV = 3'b000,
        PCOC_SW_AUTO_NONREV = 3'b001,
        PCOC_SW_MAN_AUTOFB = 3'b010,
        PCOC_SW_MAN_HOLDFB = 3'b011,
        PCOC_SW_MAN_NOFB = 3'b100
    } pcoc_swmode_e;

    typedef enum logic [1:0] {
        PCOC_LOOP_NORMAL = 2'b00,
        PCOC_LOOP_HOLD = 2'b01,
        PCOC_LOOP_FREE = 2'b10
    } pcoc_loop_e;

endpackage

//--- rtl/pcoc_chan_bank.sv
/*
 * Stored registers of one PLL channel: output control, user mode and
 * the self-clearing reset bits. Assumes decoded one-cycle write strobes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcoc_params.svh"

module pcoc_chan_bank
    import pcoc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_output,
    input wire logic wr_mode,
    input wire logic wr_reset,
    input wire pcoc_byte_t wdata,
    pcoc_ctl_if.bank ctl
);

    logic [2:0] sw_code;

    assign sw_code = wdata[`PCOC_SW_HI:`PCOC_SW_LO];

    // ------------------------------------------------------------------
    // output control
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl.out_ctl <= `PCOC_OUT_RST_VAL;
        end else if (wr_output) begin
            ctl.out_ctl <= wdata[3:0];
        end
    end

    // ------------------------------------------------------------------
    // user mode
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl.man_ref <= `PCOC_REF_RST_VAL;
            ctl.sw_mode <= PCOC_SW_AUTO_REV;
            ctl.user_hold <= 1'b0;
            ctl.user_free <= 1'b0;
        end else if (wr_mode) begin
            ctl.man_ref <= wdata[`PCOC_REF_HI:`PCOC_REF_LO];
            // unused codes keep the previous mode
            if (sw_code <= PCOC_SW_MAN_NOFB) begin
                ctl.sw_mode <= pcoc_swmode_e'(sw_code);
            end
            ctl.user_hold <= wdata[`PCOC_HOLD_BIT];
            ctl.user_free <= wdata[`PCOC_FREE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // self-clearing resets: live for one cycle only
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl.rst_act <= `PCOC_RST_RST_VAL;
        end else if (wr_reset) begin
            ctl.rst_act <= wdata[2:0];
        end else begin
            ctl.rst_act <= `PCOC_RST_RST_VAL;
        end
    end

endmodule

`default_nettype wire

//--- rtl/pcoc_loop_mode.sv
/*
 * Loop state and switchover decode for one channel. Assumes the
 * history flag comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcoc_params.svh"

module pcoc_loop_mode
    import pcoc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic history_avail,
    pcoc_ctl_if.user ctl,
    output var pcoc_loop_e loop_state,
    output logic sw_auto,
    output logic sw_revert,
    output logic fb_auto,
    output logic fb_hold
);

    pcoc_loop_e loop_next;

    // ------------------------------------------------------------------
    // forced loop state
    // ------------------------------------------------------------------
    always_comb begin
        loop_next = PCOC_LOOP_NORMAL;
        if (ctl.user_free) begin
            loop_next = PCOC_LOOP_FREE;
        end else if (ctl.user_hold && !history_avail) begin
            loop_next = PCOC_LOOP_FREE;
        end else if (ctl.user_hold) begin
            loop_next = PCOC_LOOP_HOLD;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            loop_state <= PCOC_LOOP_NORMAL;
        end else begin
            loop_state <= loop_next;
        end
    end

    // ------------------------------------------------------------------
    // switchover decode
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            sw_auto <= 1'b1;
            sw_revert <= 1'b1;
            fb_auto <= 1'b0;
            fb_hold <= 1'b0;
        end else begin
            case (ctl.sw_mode)
                PCOC_SW_AUTO_REV: begin
                    sw_auto <= 1'b1;
                    sw_revert <= 1'b1;
                    fb_auto <= 1'b0;
                    fb_hold <= 1'b0;
                end
                PCOC_SW_AUTO_NONREV: begin
                    sw_auto <= 1'b1;
                    sw_revert <= 1'b0;
                    fb_auto <= 1'b0;
                    fb_hold <= 1'b0;
                end
                PCOC_SW_MAN_AUTOFB: begin
                    sw_auto <= 1'b0;
                    sw_revert <= 1'b0;
                    fb_auto <= 1'b1;
                    fb_hold <= 1'b0;
                end
                PCOC_SW_MAN_HOLDFB: begin
                    sw_auto <= 1'b0;
                    sw_revert <= 1'b0;
                    fb_auto <= 1'b0;
                    fb_hold <= 1'b1;
                end
                default: begin
                    sw_auto <= 1'b0;
                    sw_revert <= 1'b0;
                    fb_auto <= 1'b0;
                    fb_hold <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

//--- rtl/pcoc_top.sv
/*
 * Operational control bank for the PLL channels of a clock translator:
 * output driver control, reference mode, forced loop states and
 * self-clearing loop resets, one bank per channel.
 * Assumes a byte-wide register port on CORE_CLK, a synchronous reset,
 * and loop engines that take the control levels and pulses below.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pcoc_params.svh"

module pcoc_top
    import pcoc_pkg::*;
#(
    parameter int NUM_CHAN = 2
)
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [7:0] RD_DATA,
    input wire logic [NUM_CHAN-1:0] HISTORY_AVAIL,
    output logic [NUM_CHAN-1:0] OUT_A_DRIVER_OFF,
    output logic [NUM_CHAN-1:0] OUT_B_DRIVER_OFF,
    output logic [NUM_CHAN-1:0] OUT_A_DIVIDER_OFF,
    output logic [NUM_CHAN-1:0] OUT_B_DIVIDER_OFF,
    output logic [2*NUM_CHAN-1:0] MANUAL_REF,
    output logic [NUM_CHAN-1:0] SWITCH_AUTO,
    output logic [NUM_CHAN-1:0] SWITCH_REVERTIVE,
    output logic [NUM_CHAN-1:0] FALLBACK_AUTO,
    output logic [NUM_CHAN-1:0] FALLBACK_HOLDOVER,
    output logic [NUM_CHAN-1:0] LOOP_HOLDOVER,
    output logic [NUM_CHAN-1:0] LOOP_FREE_RUN,
    output logic [NUM_CHAN-1:0] LOOP_FILTER_RST,
    output logic [NUM_CHAN-1:0] TUNING_WORD_HIST_CLR,
    output logic [NUM_CHAN-1:0] AUTOSYNC_RST
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic reg_hit(
        input logic [15:0] addr,
        input logic [15:0] ofs,
        input logic [15:0] ch
    );
        logic [15:0] chan_ofs;
        chan_ofs = 16'(ch * `PCOC_CH_STRIDE);
        return addr == 16'(ofs + chan_ofs);
    endfunction

    pcoc_byte_t chan_rd [NUM_CHAN];
    pcoc_byte_t rd_next;

    // ------------------------------------------------------------------
    // per-channel bank
    // ------------------------------------------------------------------
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        localparam logic [15:0] CH = 16'(c);

        pcoc_ctl_if ctl ();

        logic wr_output;
        logic wr_mode;
        logic wr_reset;
        pcoc_loop_e loop_state;
        logic sw_auto;
        logic sw_revert;
        logic fb_auto;
        logic fb_hold;

        assign wr_output = WR_EN && reg_hit(ADDR, `PCOC_ADDR_OUTPUT, CH);
        assign wr_mode = WR_EN && reg_hit(ADDR, `PCOC_ADDR_MODE, CH);
        assign wr_reset = WR_EN && reg_hit(ADDR, `PCOC_ADDR_RESET, CH);

        pcoc_chan_bank u_bank (
            .clk(CORE_CLK),
            .rst(RST),
            .wr_output(wr_output),
            .wr_mode(wr_mode),
            .wr_reset(wr_reset),
            .wdata(WR_DATA),
            .ctl(ctl.bank)
        );

        pcoc_loop_mode u_mode (
            .clk(CORE_CLK),
            .rst(RST),
            .history_avail(HISTORY_AVAIL[c]),
            .ctl(ctl.user),
            .loop_state(loop_state),
            .sw_auto(sw_auto),
            .sw_revert(sw_revert),
            .fb_auto(fb_auto),
            .fb_hold(fb_hold)
        );

        // --------------------------------------------------------------
        // read data of this channel
        // --------------------------------------------------------------
        always_comb begin
            chan_rd[c] = 8'h00;
            if (reg_hit(ADDR, `PCOC_ADDR_OUTPUT, CH)) begin
                chan_rd[c][3:0] = ctl.out_ctl;
            end else if (reg_hit(ADDR, `PCOC_ADDR_MODE, CH)) begin
                chan_rd[c][`PCOC_REF_HI:`PCOC_REF_LO] = ctl.man_ref;
                chan_rd[c][`PCOC_SW_HI:`PCOC_SW_LO] = ctl.sw_mode;
                chan_rd[c][`PCOC_HOLD_BIT] = ctl.user_hold;
                chan_rd[c][`PCOC_FREE_BIT] = ctl.user_free;
            end else if (reg_hit(ADDR, `PCOC_ADDR_RESET, CH)) begin
                // high only in the cycle the reset acts
                chan_rd[c][2:0] = ctl.rst_act;
            end else if (reg_hit(ADDR, `PCOC_ADDR_STATUS, CH)) begin
                chan_rd[c][`PCOC_ST_FREE] = loop_state == PCOC_LOOP_FREE;
                chan_rd[c][`PCOC_ST_HOLD] = loop_state == PCOC_LOOP_HOLD;
                chan_rd[c][`PCOC_ST_HIST] = HISTORY_AVAIL[c];
            end
        end

        // --------------------------------------------------------------
        // output drivers and dividers
        // --------------------------------------------------------------
        // power-down implies driver off too, so one bit serves both
        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                OUT_A_DRIVER_OFF[c] <= 1'b0;
                OUT_B_DRIVER_OFF[c] <= 1'b0;
                OUT_A_DIVIDER_OFF[c] <= 1'b0;
                OUT_B_DIVIDER_OFF[c] <= 1'b0;
            end else begin
                OUT_A_DRIVER_OFF[c] <= ctl.out_ctl[`PCOC_OUT_A_DIS]
                    || ctl.out_ctl[`PCOC_OUT_A_PD];
                OUT_B_DRIVER_OFF[c] <= ctl.out_ctl[`PCOC_OUT_B_DIS]
                    || ctl.out_ctl[`PCOC_OUT_B_PD];
                // divider keeps running on a plain disable: sync held
                OUT_A_DIVIDER_OFF[c] <= ctl.out_ctl[`PCOC_OUT_A_PD];
                OUT_B_DIVIDER_OFF[c] <= ctl.out_ctl[`PCOC_OUT_B_PD];
            end
        end

        // --------------------------------------------------------------
        // reference and switchover
        // --------------------------------------------------------------
        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                MANUAL_REF[2*c +: 2] <= `PCOC_REF_RST_VAL;
            end else begin
                MANUAL_REF[2*c +: 2] <= ctl.man_ref;
            end
        end

        assign SWITCH_AUTO[c] = sw_auto;
        assign SWITCH_REVERTIVE[c] = sw_revert;
        assign FALLBACK_AUTO[c] = fb_auto;
        assign FALLBACK_HOLDOVER[c] = fb_hold;

        // --------------------------------------------------------------
        // forced loop state
        // --------------------------------------------------------------
        assign LOOP_HOLDOVER[c] = loop_state == PCOC_LOOP_HOLD;
        assign LOOP_FREE_RUN[c] = loop_state == PCOC_LOOP_FREE;

        // --------------------------------------------------------------
        // loop reset pulses
        // --------------------------------------------------------------
        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                LOOP_FILTER_RST[c] <= 1'b0;
                TUNING_WORD_HIST_CLR[c] <= 1'b0;
                AUTOSYNC_RST[c] <= 1'b0;
            end else begin
                LOOP_FILTER_RST[c] <= ctl.rst_act[`PCOC_RST_FILT];
                TUNING_WORD_HIST_CLR[c] <=
                    ctl.rst_act[`PCOC_RST_HIST];
                AUTOSYNC_RST[c] <= ctl.rst_act[`PCOC_RST_SYNC];
            end
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // at most one channel matches, so an or-merge is enough
    always_comb begin
        rd_next = 8'h00;
        for (int i = 0; i < NUM_CHAN; i++) begin
            rd_next = rd_next | chan_rd[i];
        end
    end

    // unmapped addresses read zero; data holds one cycle only
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            RD_DATA <= 8'h00;
        end else if (RD_EN) begin
            RD_DATA <= rd_next;
        end else begin
            RD_DATA <= 8'h00;
        end
    end

endmodule

`default_nettype wire

//--- test/pcoc_top_sva.sv
/*
 * Assertion checker for the PLL channel control bank top.
 * Assumes NUM_CHAN of at least 2 and one clock, bound to the top below.
 */
`timescale 1ns/1ps
`default_nettype none

module pcoc_top_sva #(
    parameter int NUM_CHAN = 2
)
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] RD_DATA,
    input wire logic [NUM_CHAN-1:0] HISTORY_AVAIL,
    input wire logic [NUM_CHAN-1:0] OUT_A_DRIVER_OFF,
    input wire logic [NUM_CHAN-1:0] OUT_B_DRIVER_OFF,
    input wire logic [NUM_CHAN-1:0] OUT_A_DIVIDER_OFF,
    input wire logic [NUM_CHAN-1:0] OUT_B_DIVIDER_OFF,
    input wire logic [2*NUM_CHAN-1:0] MANUAL_REF,
    input wire logic [NUM_CHAN-1:0] SWITCH_AUTO,
    input wire logic [NUM_CHAN-1:0] SWITCH_REVERTIVE,
    input wire logic [NUM_CHAN-1:0] FALLBACK_AUTO,
    input wire logic [NUM_CHAN-1:0] FALLBACK_HOLDOVER,
    input wire logic [NUM_CHAN-1:0] LOOP_HOLDOVER,
    input wire logic [NUM_CHAN-1:0] LOOP_FREE_RUN,
    input wire logic [NUM_CHAN-1:0] LOOP_FILTER_RST,
    input wire logic [NUM_CHAN-1:0] TUNING_WORD_HIST_CLR,
    input wire logic [NUM_CHAN-1:0] AUTOSYNC_RST
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // fields split out so that $past sees plain signals, apart from the HISTORY_AVAIL[0] bit-select
    wire logic a_off = WR_DATA[2] | WR_DATA[0];
    wire logic b_off = WR_DATA[3] | WR_DATA[1];
    wire logic b_pd = WR_DATA[1];
    wire logic [1:0] ref_d = WR_DATA[6:5];
    wire logic [2:0] sw_d = WR_DATA[4:2];
    wire logic [3:0] lo_d = WR_DATA[3:0];
    wire logic filt_wr = WR_EN && ADDR == 16'h0A23 && WR_DATA[2];
    wire logic hist1_wr = WR_EN && ADDR == 16'h0A43 && WR_DATA[1];

    function automatic logic [3:0] sw_exp(input logic [2:0] m);
        case (m)
            3'h0: return 4'hC;
            3'h1: return 4'h8;
            3'h2: return 4'h2;
            3'h3: return 4'h1;
            default: return 4'h0;
        endcase
    endfunction

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    sequence s_wr(a, c);
        WR_EN && ADDR == a && c;
    endsequence

    sequence s_rd(a);
        RD_EN && ADDR == a;
    endsequence

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    chk_drv_a: assert property (
        s_wr(16'h0A21, 1'b1) |-> ##2 OUT_A_DRIVER_OFF[0] == $past(a_off, 2))
        else $error("output A driver state differs from written bits");
    chk_out_b: assert property (
        s_wr(16'h0A21, 1'b1) |-> ##2
        {OUT_B_DRIVER_OFF[0], OUT_B_DIVIDER_OFF[0]} ==
        {$past(b_off, 2), $past(b_pd, 2)})
        else $error("output B driver or divider state is wrong");
    chk_ch1_drv: assert property (
        s_wr(16'h0A41, 1'b1) |-> ##2 OUT_A_DRIVER_OFF[1] == $past(a_off, 2))
        else $error("second channel output A driver state is wrong");
    chk_ref_sel: assert property (
        s_wr(16'h0A22, 1'b1) |-> ##2 MANUAL_REF[1:0] == $past(ref_d, 2))
        else $error("manual reference differs from written field");
    chk_sw_mode: assert property (
        s_wr(16'h0A22, WR_DATA[4:2] <= 3'h4) |-> ##2
        {SWITCH_AUTO[0], SWITCH_REVERTIVE[0], FALLBACK_AUTO[0],
        FALLBACK_HOLDOVER[0]} == sw_exp($past(sw_d, 2)))
        else $error("switching mode decode is wrong");
    chk_free_wins: assert property (
        s_wr(16'h0A22, WR_DATA[0]) |-> ##2
        LOOP_FREE_RUN[0] && !LOOP_HOLDOVER[0])
        else $error("free run not forced after its bit was written");
    chk_hold_hist: assert property (
        LOOP_HOLDOVER[0] |-> $past(HISTORY_AVAIL[0]))
        else $error("holdover shown without tuning word history");
    chk_filt_pulse: assert property (
        LOOP_FILTER_RST[0] == $past(filt_wr, 2))
        else $error("loop filter reset pulse wrong in time or length");
    chk_hist_pulse: assert property (
        TUNING_WORD_HIST_CLR[1] == $past(hist1_wr, 2))
        else $error("second channel history clear pulse is wrong");
    chk_rd_idle: assert property (
        !RD_EN |=> RD_DATA == 8'h00)
        else $error("read data not zero outside the read cycle");
    chk_rd_back: assert property (
        s_wr(16'h0A21, 1'b1) ##1 !WR_EN ##1 !WR_EN ##1 s_rd(16'h0A21)
        |=> RD_DATA == {4'h0, $past(lo_d, 4)})
        else $error("output control readback differs from write");
endmodule

bind pcoc_top pcoc_top_sva #(.NUM_CHAN(NUM_CHAN)) i_pcoc_top_sva (
    .CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
    .HISTORY_AVAIL(HISTORY_AVAIL), .OUT_A_DRIVER_OFF(OUT_A_DRIVER_OFF),
    .OUT_B_DRIVER_OFF(OUT_B_DRIVER_OFF),
    .OUT_A_DIVIDER_OFF(OUT_A_DIVIDER_OFF),
    .OUT_B_DIVIDER_OFF(OUT_B_DIVIDER_OFF), .MANUAL_REF(MANUAL_REF),
    .SWITCH_AUTO(SWITCH_AUTO), .SWITCH_REVERTIVE(SWITCH_REVERTIVE),
    .FALLBACK_AUTO(FALLBACK_AUTO), .FALLBACK_HOLDOVER(FALLBACK_HOLDOVER),
    .LOOP_HOLDOVER(LOOP_HOLDOVER), .LOOP_FREE_RUN(LOOP_FREE_RUN),
    .LOOP_FILTER_RST(LOOP_FILTER_RST),
    .TUNING_WORD_HIST_CLR(TUNING_WORD_HIST_CLR),
    .AUTOSYNC_RST(AUTOSYNC_RST)
);

`default_nettype wire

//--- test/pcoc_top_tb.sv
/*
 * Self-checking bench for the PLL channel control bank top.
 * Assumes the default of two channels and a 50 MHz core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pcoc_top_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [1:0] hist_avail = 2'h0;
    logic [7:0] rd_data;
    logic [1:0] drv_a, drv_b, div_a, div_b, sw_auto, sw_rev, fb_auto;
    logic [1:0] fb_hold, lp_hold, lp_free, filt_rst, hist_clr, sync_rst;
    logic [3:0] man_ref;
    logic [7:0] d, o, x;
    logic [15:0] base;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;

    pcoc_top #(.NUM_CHAN(2)) i_pcoc_top (
        .CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .WR_DATA(wr_data),
        .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
        .HISTORY_AVAIL(hist_avail), .OUT_A_DRIVER_OFF(drv_a),
        .OUT_B_DRIVER_OFF(drv_b), .OUT_A_DIVIDER_OFF(div_a),
        .OUT_B_DIVIDER_OFF(div_b), .MANUAL_REF(man_ref),
        .SWITCH_AUTO(sw_auto), .SWITCH_REVERTIVE(sw_rev),
        .FALLBACK_AUTO(fb_auto), .FALLBACK_HOLDOVER(fb_hold),
        .LOOP_HOLDOVER(lp_hold), .LOOP_FREE_RUN(lp_free),
        .LOOP_FILTER_RST(filt_rst), .TUNING_WORD_HIST_CLR(hist_clr),
        .AUTOSYNC_RST(sync_rst)
    );

    // packed views; pulse pairs are filter, history, autosync
    wire logic [7:0] lp0 = {6'h00, lp_hold[0], lp_free[0]};
    wire logic [7:0] sw0 = {4'h0, sw_auto[0], sw_rev[0], fb_auto[0],
        fb_hold[0]};
    wire logic [7:0] pls = {2'h0, filt_rst, hist_clr, sync_rst};

    always #10 core_clk = ~core_clk;

    // ------------------------------------------------------------------
    // access and checking tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp,
                      input string name);
        @(posedge core_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        check(name, rd_data, exp);
    endtask

    // controls land one edge after the write edge
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask

    function automatic logic [7:0] sw_exp(input int m);
        case (m)
            0: return 8'h0C;
            1: return 8'h08;
            2: return 8'h02;
            3: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction

    task automatic print_verdict;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // hang guard and main sequence
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        tick;
        check("out_rst", {drv_b, drv_a, div_b, div_a}, 8'h00);
        check("sw_rst", {sw_auto, sw_rev, fb_auto, fb_hold}, 8'hF0);
        check("ref_rst", {4'h0, man_ref}, 8'h00);
        check("loop_rst", {4'h0, lp_hold, lp_free}, 8'h00);
        check("pulse_rst", pls, 8'h00);
        for (int c = 0; c < 2; c++) begin
            base = 16'(c * 32);
            rd(16'h0A21 + base, 8'h00, "out_rd");
            rd(16'h0A22 + base, 8'h00, "mode_rd");
            rd(16'h0A23 + base, 8'h00, "rst_rd");
            for (int i = 0; i < 4; i++) begin
                d = 8'h01 << i;
                wr(16'h0A21 + base, d);
                tick;
                o = {4'h0, drv_b[c], drv_a[c], div_b[c], div_a[c]};
                x = {4'h0, d[3:2] | d[1:0], d[1:0]};
                check("out_pins", o, x);
                rd(16'h0A21 + base, d, "out_back");
            end
            wr(16'h0A21 + base, 8'h00);
        end
        for (int m = 0; m < 5; m++) begin
            d = {1'b0, 2'(m), 3'(m), 2'b00};
            wr(16'h0A22, d);
            tick;
            check("ref_pin", {6'h00, man_ref[1:0]}, {6'h00, d[6:5]});
            check("sw_pins", sw0, sw_exp(m));
            rd(16'h0A22, d, "mode_back");
        end
        // unused switching code keeps the stored mode
        wr(16'h0A22, 8'h54);
        rd(16'h0A22, 8'h50, "mode_unused");
        wr(16'h0A42, 8'h60);
        tick;
        check("ref_ch1", {6'h00, man_ref[3:2]}, 8'h03);
        wr(16'h0A22, 8'h00);
        @(posedge core_clk);
        hist_avail <= 2'h3;
        wr(16'h0A22, 8'h02);
        tick;
        check("hold", lp0, 8'h02);
        repeat (3) tick;
        check("hold_kept", lp0, 8'h02);
        @(posedge core_clk);
        hist_avail <= 2'h2;
        tick;
        check("hold_nohist", lp0, 8'h01);
        rd(16'h0A2F, 8'h01, "status");
        @(posedge core_clk);
        hist_avail <= 2'h3;
        tick;
        check("hold_back", lp0, 8'h02);
        wr(16'h0A22, 8'h03);
        tick;
        check("both_set", lp0, 8'h01);
        wr(16'h0A22, 8'h01);
        tick;
        check("free", lp0, 8'h01);
        wr(16'h0A22, 8'h00);
        tick;
        check("normal", lp0, 8'h00);
        wr(16'h0A23, 8'h07);
        tick;
        check("pulse_on", pls, 8'h15);
        tick;
        check("pulse_off", pls, 8'h00);
        rd(16'h0A23, 8'h00, "rst_clear");
        wr(16'h0A23, 8'h00);
        tick;
        check("zero_wr", pls, 8'h00);
        wr(16'h0A43, 8'h02);
        tick;
        check("ch1_hist", {6'h00, hist_clr}, 8'h02);
        // two filter resets on consecutive edges give two pulse cycles
        @(posedge core_clk);
        wr_en <= 1'b1;
        addr <= 16'h0A23;
        wr_data <= 8'h04;
        repeat (2) @(posedge core_clk);
        wr_en <= 1'b0;
        #1;
        for (int k = 0; k < 3; k++) begin
            check("b2b_pulse", pls, (k < 2) ? 8'h10 : 8'h00);
            tick;
        end
        wr(16'h0A25, 8'hFF);
        rd(16'h0A25, 8'h00, "unmapped");
        print_verdict();
    end
endmodule

`default_nettype wire
